/* File: rtl/csr_status_top.sv */
`timescale 1ns/100ps
`include "csr_cfg.svh"

// Functional notes
// - thermal-loop flag shows regulation limiting charge
// - turn-on: thermal flag nonzero raises interrupt
// - later thermal flag toggles raise interrupt
// - safety-timer flag shows timer expiry
// - turn-on: safety flag nonzero raises interrupt
// - later safety flag toggles raise interrupt
module csr_status_top #(
    // two-wire target address, arbitrary value
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // charger condition inputs
    input wire logic [2:0] temp_zone_code,
    input wire logic cell_absent,
    input wire logic charge_done,
    input wire logic input_power_valid,
    input wire logic thermal_loop_active,
    input wire logic safety_timer_expired,
    input wire logic pmu_on,
    // two-wire bus, data line open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // interrupt pin, open drain, active low
    output logic irq_n_out,
    output logic irq_n_oe,
    // status view
    output csr_pkg::csr_byte_type status_flags
);
    import csr_pkg::*;

    // ==========================================
    // state
    csr_state_type state_q;
    csr_state_type state_d;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    csr_byte_type shreg_q;
    csr_byte_type shreg_d;
    csr_byte_type ptr_q;
    csr_byte_type ptr_d;
    csr_byte_type status_q;
    csr_byte_type status_d;
    csr_byte_type load_byte;
    logic rw_q;
    logic rw_d;
    logic first_q;
    logic first_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic irq_pend_q;
    logic irq_pend_d;
    logic rd_done;
    logic status_evt;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // only the status byte is mapped; everything else reads zero
    function automatic csr_byte_type read_byte(input csr_byte_type ptr,
                                               input csr_byte_type stat);
        if (ptr == `CSR_STATUS_OFS) begin
            read_byte = stat;
        end else begin
            read_byte = `CSR_UNMAPPED_RD;
        end
    endfunction

    // ==========================================
    // status capture
    always_comb begin
        status_d = '0;
        status_d[`CSR_TEMP_ZONE_MSB:`CSR_TEMP_ZONE_LSB] = temp_zone_code;
        status_d[`CSR_CELL_ABSENT_BIT] = cell_absent;
        status_d[`CSR_CHARGE_DONE_BIT] = charge_done;
        status_d[`CSR_POWER_VALID_BIT] = input_power_valid;
        status_d[`CSR_THERMAL_BIT] = thermal_loop_active;
        status_d[`CSR_SAFETY_BIT] = safety_timer_expired;
    end

    // every field gets the same turn-on compare and toggle watch
    csr_change_watch #(
        .WIDTH(8)
    ) u_watch (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pmu_on(pmu_on),
        .value(status_q),
        .evt(status_evt)
    );

    // ==========================================
    // interrupt: held until the status byte is read out
    always_comb begin
        // a new event in the clearing cycle keeps the pin low
        irq_pend_d = status_evt | (irq_pend_q & ~rd_done);
    end

    // ==========================================
    // two-wire target
    always_comb begin
        scl_rise = ~scl_q & scl_in;
        scl_fall = scl_q & ~scl_in;
        start_cond = scl_q & scl_in & sda_q & ~sda_in;
        stop_cond = scl_q & scl_in & ~sda_q & sda_in;
        load_byte = read_byte(ptr_q, status_q);
    end

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shreg_d = shreg_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        first_d = first_q;
        sda_oe_d = sda_oe_q;
        rd_done = 1'b0;
        if (start_cond) begin
            state_d = CSR_ADDR;
            bit_cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else if (stop_cond) begin
            state_d = CSR_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            case (state_q)
                CSR_IDLE: begin
                    sda_oe_d = 1'b0;
                end
                CSR_ADDR, CSR_WR_BYTE: begin
                    if (scl_rise && bit_cnt_q < `CSR_BITS_PER_BYTE) begin
                        shreg_d = {shreg_q[6:0], sda_in};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    if (scl_fall && bit_cnt_q == `CSR_BITS_PER_BYTE) begin
                        if (state_q == CSR_WR_BYTE) begin
                            // data writes are acknowledged but change nothing
                            if (first_q) begin
                                ptr_d = shreg_q;
                            end
                            first_d = 1'b0;
                            state_d = CSR_ACK_WR;
                            sda_oe_d = 1'b1;
                        end else if (shreg_q[7:1] == DEV_ADDR) begin
                            rw_d = shreg_q[0];
                            first_d = 1'b1;
                            state_d = CSR_ACK_ADDR;
                            sda_oe_d = 1'b1;
                        end else begin
                            state_d = CSR_IDLE;
                        end
                    end
                end
                CSR_ACK_ADDR: begin
                    if (scl_fall) begin
                        bit_cnt_d = 4'h0;
                        if (rw_q) begin
                            shreg_d = load_byte;
                            sda_oe_d = ~load_byte[7];
                            state_d = CSR_RD_BYTE;
                        end else begin
                            sda_oe_d = 1'b0;
                            state_d = CSR_WR_BYTE;
                        end
                    end
                end
                CSR_ACK_WR: begin
                    if (scl_fall) begin
                        bit_cnt_d = 4'h0;
                        sda_oe_d = 1'b0;
                        state_d = CSR_WR_BYTE;
                    end
                end
                CSR_RD_BYTE: begin
                    if (scl_rise) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                    if (scl_fall) begin
                        if (bit_cnt_q == `CSR_BITS_PER_BYTE) begin
                            sda_oe_d = 1'b0;
                            state_d = CSR_RD_ACK;
                        end else begin
                            shreg_d = {shreg_q[6:0], 1'b0};
                            sda_oe_d = ~shreg_q[6];
                        end
                    end
                end
                CSR_RD_ACK: begin
                    if (scl_rise) begin
                        rd_done = ptr_q == `CSR_STATUS_OFS;
                        ptr_d = ptr_q + 8'h01;
                        if (sda_in) begin
                            // controller said no more
                            state_d = CSR_IDLE;
                        end
                    end
                    if (scl_fall) begin
                        bit_cnt_d = 4'h0;
                        shreg_d = load_byte;
                        sda_oe_d = ~load_byte[7];
                        state_d = CSR_RD_BYTE;
                    end
                end
                default: begin
                    state_d = CSR_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= CSR_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            sda_oe_q <= 1'b0;
            irq_pend_q <= 1'b0;
            status_q <= `CSR_STATUS_RST;
        end else begin
            state_q <= state_d;
            scl_q <= scl_in;
            sda_q <= sda_in;
            bit_cnt_q <= bit_cnt_d;
            shreg_q <= shreg_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            first_q <= first_d;
            sda_oe_q <= sda_oe_d;
            irq_pend_q <= irq_pend_d;
            status_q <= status_d;
        end
    end

    assign sda_out = 1'b0;
    assign irq_n_out = 1'b0;
    assign sda_oe = sda_oe_q;
    assign irq_n_oe = irq_pend_q;
    assign status_flags = status_q;
endmodule

/* File: rtl/csr_cfg.svh */
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// ==========================================
// register map
`define CSR_STATUS_OFS 8'h0a
`define CSR_STATUS_RST 8'h00
`define CSR_UNMAPPED_RD 8'h00

// ==========================================
// status field positions
`define CSR_TEMP_ZONE_MSB 7
`define CSR_TEMP_ZONE_LSB 5
`define CSR_CELL_ABSENT_BIT 4
`define CSR_CHARGE_DONE_BIT 3
`define CSR_POWER_VALID_BIT 2
`define CSR_THERMAL_BIT 1
`define CSR_SAFETY_BIT 0

// ==========================================
// two-wire bus framing
`define CSR_BITS_PER_BYTE 4'h8
// value every status bit is held against at turn-on
`define CSR_POWERON_REF 8'h00

`endif

/* File: rtl/csr_pkg.sv */
package csr_pkg;

    // ==========================================
    // two-wire target states, one-hot
    typedef enum logic [6:0] {
        CSR_IDLE = 7'h01,
        CSR_ADDR = 7'h02,
        CSR_ACK_ADDR = 7'h04,
        CSR_WR_BYTE = 7'h08,
        CSR_ACK_WR = 7'h10,
        CSR_RD_BYTE = 7'h20,
        CSR_RD_ACK = 7'h40
    } csr_state_type;

    typedef logic [7:0] csr_byte_type;

endpackage

/* File: rtl/csr_change_watch.sv */
`timescale 1ns/100ps
`include "csr_cfg.svh"

module csr_change_watch #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // watched value and power state
    input wire logic pmu_on,
    input wire logic [WIDTH-1:0] value,
    // one-cycle event
    output logic evt
);
    logic on_q;
    logic on_d;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;
    logic [WIDTH-1:0] hit;
    logic evt_q;
    logic evt_d;
    logic [WIDTH-1:0] ref_val;

    assign ref_val = WIDTH'(`CSR_POWERON_REF);

    // ==========================================
    // per-bit compare: turn-on against zero, later any toggle
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                if (!pmu_on) begin
                    hit[i] = 1'b0;
                end else if (!on_q) begin
                    hit[i] = value[i] != ref_val[i];
                end else begin
                    hit[i] = value[i] != prev_q[i];
                end
            end
        end
    endgenerate

    always_comb begin
        on_d = pmu_on;
        prev_d = value;
        evt_d = |hit;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            on_q <= 1'b0;
            prev_q <= '0;
            evt_q <= 1'b0;
        end else begin
            on_q <= on_d;
            prev_q <= prev_d;
            evt_q <= evt_d;
        end
    end

    assign evt = evt_q;
endmodule

/* File: bench/csr_status_top_monitor.sv */
`timescale 1ns/100ps
module csr_status_top_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // charger inputs
    input wire logic [2:0] temp_zone_code,
    input wire logic cell_absent,
    input wire logic charge_done,
    input wire logic input_power_valid,
    input wire logic thermal_loop_active,
    input wire logic safety_timer_expired,
    input wire logic pmu_on,
    // outputs watched
    input wire logic irq_n_oe,
    input wire csr_pkg::csr_byte_type status_flags
);
    import csr_pkg::*;
    wire logic [7:0] raw = {temp_zone_code, cell_absent, charge_done, input_power_valid,
        thermal_loop_active, safety_timer_expired};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // status view
    // guard: the first edge after reset still sees the reset-time inputs
    a_done_bit: assert property (!$past(sys_rst) |-> status_flags[3] == $past(raw[3]))
        else $error("done bit wrong");
    a_thermal_bit: assert property (!$past(sys_rst) |-> status_flags[1] == $past(raw[1]))
        else $error("thermal bit wrong");
    a_safety_bit: assert property (!$past(sys_rst) |-> status_flags[0] == $past(raw[0]))
        else $error("safety bit wrong");
    a_status_follow: assert property (!$past(sys_rst) |-> status_flags == $past(raw))
        else $error("status byte wrong");
    // ==========================================
    // interrupt events
    a_thermal_on: assert property ($rose(pmu_on) && status_flags[1] |-> ##[1:3] irq_n_oe)
        else $error("no irq at turn-on, thermal");
    a_safety_on: assert property ($rose(pmu_on) && status_flags[0] |-> ##[1:3] irq_n_oe)
        else $error("no irq at turn-on, safety");
    a_thermal_toggle: assert property (pmu_on && $past(pmu_on) && !$past(sys_rst)
        && $changed(status_flags[1]) |-> ##[1:3] irq_n_oe) else $error("no irq on thermal");
    a_safety_toggle: assert property (pmu_on && $past(pmu_on) && !$past(sys_rst)
        && $changed(status_flags[0]) |-> ##[1:3] irq_n_oe) else $error("no irq on safety");
    a_field_toggle: assert property (pmu_on && $past(pmu_on) && !$past(sys_rst)
        && $changed(status_flags[7:2]) |-> ##[1:3] irq_n_oe) else $error("no irq on field");
    c_irq_set: cover property ($rose(irq_n_oe));
    c_irq_clear: cover property ($fell(irq_n_oe));
    c_turn_on: cover property ($rose(pmu_on) && status_flags != 8'h00);
endmodule

bind csr_status_top csr_status_top_monitor u_mon (.core_clk, .sys_rst, .temp_zone_code,
    .cell_absent, .charge_done, .input_power_valid, .thermal_loop_active,
    .safety_timer_expired, .pmu_on, .irq_n_oe, .status_flags);

/* File: bench/csr_host.sv */
`timescale 1ns/100ps
// ==========================================
// two-wire controller model; sda high means released
module csr_host (
    // clock
    input wire logic core_clk,
    // resolved data line
    input wire logic sda_line,
    // driven lines
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic start;
        sda = 1'b1;
        w(2);
        scl = 1'b1;
        w(4);
        sda = 1'b0;
        w(4);
        scl = 1'b0;
        w(2);
    endtask
    task automatic stop;
        sda = 1'b0;
        w(2);
        scl = 1'b1;
        w(4);
        sda = 1'b1;
        w(4);
    endtask
    // sda held 2 cycles past scl fall: target sees scl one cycle late
    task automatic bit_x(input logic b, output logic r);
        sda = b;
        w(2);
        scl = 1'b1;
        w(2);
        r = sda_line;
        w(2);
        scl = 1'b0;
        w(2);
    endtask
    task automatic byte_x(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
        output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(ai, ao);
    endtask
endmodule

/* File: bench/tb.sv */
`timescale 1ns/100ps
module tb;
    import csr_pkg::*;
    localparam logic [6:0] ADR = 7'h2a;
    localparam csr_byte_type PAT [6] = '{8'h02, 8'h01, 8'h10, 8'h08, 8'h04, 8'ha0};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pmu_on = 1'b0;
    csr_byte_type st_in = 8'h00;
    logic sda_out, sda_oe, irq_n_out, irq_n_oe, scl, sda;
    csr_byte_type status_flags;
    csr_byte_type d;
    csr_byte_type d2;
    int err_total = 0;
    int cmp_count = 0;
    // open-drain data line with its pull-up: the target's low value wins while enabled
    wire logic sda_line = sda & (sda_oe ? sda_out : 1'b1);
    csr_host host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda(sda));
    csr_status_top #(.DEV_ADDR(ADR)) u_csr_status_top (.core_clk(core_clk), .sys_rst(sys_rst),
        .temp_zone_code(st_in[7:5]), .cell_absent(st_in[4]), .charge_done(st_in[3]),
        .input_power_valid(st_in[2]), .thermal_loop_active(st_in[1]),
        .safety_timer_expired(st_in[0]), .pmu_on(pmu_on), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
        .status_flags(status_flags));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // ==========================================
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input csr_byte_type g, input csr_byte_type e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // interrupt pin as the board sees it: pulled up, low while asserted
    task automatic chk_irq(input logic e);
        logic pin;
        pin = irq_n_oe ? irq_n_out : 1'b1;
        cmp_count++;
        if (pin !== ~e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, ~pin, e);
        end
    endtask
    task automatic rd(input csr_byte_type p, output csr_byte_type v);
        logic a;
        csr_byte_type x;
        host.start();
        host.byte_x({ADR, 1'b0}, 1'b1, x, a);
        host.byte_x(p, 1'b1, x, a);
        host.start();
        host.byte_x({ADR, 1'b1}, 1'b1, x, a);
        host.byte_x(8'hff, 1'b1, v, a);
        host.stop();
    endtask
    // two bytes in one read; the pointer steps on after every byte, acked or not
    task automatic rd_pair(input csr_byte_type p, output csr_byte_type v0,
        output csr_byte_type v1);
        logic a;
        csr_byte_type x;
        host.start();
        host.byte_x({ADR, 1'b0}, 1'b1, x, a);
        host.byte_x(p, 1'b1, x, a);
        host.start();
        host.byte_x({ADR, 1'b1}, 1'b1, x, a);
        host.byte_x(8'hff, 1'b0, v0, a);
        host.byte_x(8'hff, 1'b1, v1, a);
        host.stop();
    endtask
    // returns the three acks; 1 means not acknowledged
    task automatic wr(input logic [6:0] ad, input csr_byte_type p, output csr_byte_type k);
        csr_byte_type x;
        k = 8'h00;
        host.start();
        host.byte_x({ad, 1'b0}, 1'b1, x, k[2]);
        host.byte_x(p, 1'b1, x, k[1]);
        host.byte_x(8'hff, 1'b1, x, k[0]);
        host.stop();
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
    // ==========================================
    // tests
    initial begin
        cyc(3);
        sys_rst = 1'b0;
        cyc(2);
        chk(status_flags, 8'h00);
        chk_irq(1'b0);
        foreach (PAT[i]) begin
            st_in = PAT[i];
            cyc(4);
            chk(status_flags, PAT[i]);
            chk_irq(1'b0);
        end
        $display("test field map done");
        foreach (PAT[i]) begin
            pmu_on = 1'b0;
            st_in = PAT[i];
            cyc(3);
            pmu_on = 1'b1;
            cyc(5);
            chk_irq(1'b1);
            rd(8'h0a, d);
            chk(d, PAT[i]);
            chk_irq(1'b0);
        end
        pmu_on = 1'b0;
        st_in = 8'h00;
        cyc(3);
        pmu_on = 1'b1;
        cyc(5);
        chk_irq(1'b0);
        $display("test turn-on done");
        foreach (PAT[i]) begin
            for (int k = 0; k < 2; k++) begin
                st_in = st_in ^ PAT[i];
                cyc(5);
                chk_irq(1'b1);
                rd(8'h0a, d);
                chk(d, st_in);
                chk_irq(1'b0);
            end
        end
        $display("test toggle done");
        st_in = 8'h5a;
        cyc(5);
        wr(ADR, 8'h0a, d);
        chk(d, 8'h00);
        wr(ADR ^ 7'h01, 8'h0a, d);
        chk(d, 8'h07);
        rd(8'h0b, d);
        chk(d, 8'h00);
        chk_irq(1'b1);
        rd(8'h0a, d);
        chk(d, 8'h5a);
        chk_irq(1'b0);
        // safety bit toggles, then a two-byte read walks from 0x09 into the status byte
        st_in = 8'h5b;
        cyc(5);
        chk_irq(1'b1);
        rd_pair(8'h09, d, d2);
        chk(d, 8'h00);
        chk(d2, 8'h5b);
        chk_irq(1'b0);
        $display("test read only done");
        report_and_stop();
    end
endmodule
